/* File: logic/dual_cpu_ram_block_mapper.sv */
// Block mapper and shared four block RAM card for two processors.
`include "ram_mapper_map.svh"
`default_nettype none
module dual_cpu_ram_block_mapper (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [1:0] mapWr,
    input wire logic [3:0] mapIndex,
    input wire logic [7:0] mapData,
    input wire logic [1:0] memReq,
    input wire logic [1:0] memWr,
    input wire logic [31:0] memAddr,
    input wire logic [15:0] memWdata,
    output logic [15:0] memRdata,
    output logic [1:0] memRvalid
);

    // Card storage, four physical blocks of 16K bytes.
    ram_mapper_pkg::byte_t card [0:(`NUM_PBLK << `OFS_W) - 1];

    wire ram_mapper_pkg::addr_t cpuAddr [0:`NUM_CPU-1];

    wire ram_mapper_pkg::byte_t cpuWdata [0:`NUM_CPU-1];

    wire ram_mapper_pkg::byte_t cpuEntry [0:`NUM_CPU-1];

    wire ram_mapper_pkg::addr_t cpuCardAddr [0:`NUM_CPU-1];

    wire ram_mapper_pkg::byte_t cpuRdByte [0:`NUM_CPU-1];

    wire logic [`NUM_CPU-1:0] readReq;

    wire logic [`NUM_CPU-1:0] writeReq;

    wire logic [`NUM_CPU-1:0] privHit;

    wire logic [`NUM_CPU-1:0] cardWrEn;

    assign readReq = memReq & ~memWr;

    assign writeReq = memReq & memWr;

    function automatic logic isPriv(input ram_mapper_pkg::addr_t a);
        isPriv = a >= `PRIV_BASE;
    endfunction : isPriv

    // Block numbers 4 to 7 all have the top field bit set.
    function automatic logic cardSel(input ram_mapper_pkg::byte_t e);
        cardSel = e[`MAP_PB_MSB] == 1'b0;
    endfunction : cardSel

    // A read-only or deselected entry must never reach the card array.
    function automatic logic writeOk(input ram_mapper_pkg::byte_t e);
        writeOk = cardSel(e) && e[`MAP_WE_BIT];
    endfunction : writeOk

    function automatic logic [`LBLK_W-1:0] logicalBlock(input ram_mapper_pkg::addr_t a);
        logicalBlock = a[`ADDR_W-1:`BLK_LSB];
    endfunction : logicalBlock

    function automatic logic [`PRIV_W-1:0] privOffset(input ram_mapper_pkg::addr_t a);
        privOffset = a[`PRIV_W-1:0];
    endfunction : privOffset

    // Physical block bits replace the logical block bits.
    function automatic ram_mapper_pkg::addr_t cardIndex(
        input ram_mapper_pkg::byte_t e,
        input ram_mapper_pkg::addr_t a
    );
        cardIndex = {e[`MAP_PB_MSB-1:`MAP_PB_LSB], a[`OFS_W-1:0]};
    endfunction : cardIndex

    genvar p;

    generate
        for (p = 0; p < `NUM_CPU; p++) begin : g_cpu
            // Each processor owns its map, so one map write never reaches the other.
            ram_mapper_pkg::byte_t mapEnt [0:`NUM_LBLK-1];

            // Private static region, one copy per processor.
            ram_mapper_pkg::byte_t priv [0:(1 << `PRIV_W) - 1];

            logic [`LBLK_W-1:0] wrSlot;

            logic [`MAP_NIB_W-1:0] wrNib;

            logic [`LBLK_W-1:0] rdSlot;

            ram_mapper_pkg::byte_t next_rdByte;

            assign cpuAddr[p] = memAddr[`ADDR_W*p +: `ADDR_W];

            assign cpuWdata[p] = memWdata[`DATA_W*p +: `DATA_W];

            assign wrSlot = mapIndex[`LBLK_W*p +: `LBLK_W];

            assign wrNib = mapData[`MAP_NIB_W*p +: `MAP_NIB_W];

            assign rdSlot = logicalBlock(cpuAddr[p]);

            assign cpuEntry[p] = mapEnt[rdSlot];

            assign cpuCardAddr[p] = cardIndex(cpuEntry[p], cpuAddr[p]);

            assign privHit[p] = isPriv(cpuAddr[p]);

            assign cardWrEn[p] = writeReq[p] && !privHit[p] && writeOk(cpuEntry[p]);

            // The map keeps only the low nibble, so the upper entry bits stay zero.
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    for (int i = 0; i < `NUM_LBLK; i++) begin
                        mapEnt[i] <= `MAP_RST;
                    end
                end else if (mapWr[p]) begin
                    mapEnt[wrSlot] <= {{(`DATA_W - `MAP_NIB_W){1'b0}}, wrNib};
                end
            end

            always_ff @(posedge mclk) begin
                if (!sys_rst && writeReq[p] && privHit[p]) begin
                    priv[privOffset(cpuAddr[p])] <= cpuWdata[p];
                end
            end

            // The private region wins over the map; a deselected card floats high.
            always_comb begin
                next_rdByte = `FLOAT_DATA;
                case ({privHit[p], cardSel(cpuEntry[p])})
                    2'b10, 2'b11: begin
                        next_rdByte = priv[privOffset(cpuAddr[p])];
                    end
                    2'b01: begin
                        next_rdByte = card[cpuCardAddr[p]];
                    end
                    default: begin
                        next_rdByte = `FLOAT_DATA;
                    end
                endcase
            end

            assign cpuRdByte[p] = next_rdByte;

        end
    endgenerate

    // Processor 1 is visited last, so it wins a same cycle write to one byte.
    always_ff @(posedge mclk) begin
        if (!sys_rst) begin
            for (int i = 0; i < `NUM_CPU; i++) begin
                if (cardWrEn[i]) begin
                    card[cpuCardAddr[i]] <= cpuWdata[i];
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            memRvalid <= '0;
        end else begin
            memRvalid <= readReq;
        end
    end

    // Read data holds until the next read, so a slow core may pick it up late.
    always_ff @(posedge mclk) begin
        for (int i = 0; i < `NUM_CPU; i++) begin
            if (sys_rst) begin
                memRdata[`DATA_W*i +: `DATA_W] <= `FLOAT_DATA;
            end else if (readReq[i]) begin
                memRdata[`DATA_W*i +: `DATA_W] <= cpuRdByte[i];
            end
        end
    end

endmodule : dual_cpu_ram_block_mapper
`default_nettype wire

/* File: logic/ram_mapper_map.svh */
// Constants for the dual processor RAM block mapper.
`ifndef RAM_MAPPER_MAP_SVH
`define RAM_MAPPER_MAP_SVH
`define ADDR_W 16
`define BLK_LSB 14
`define OFS_W 14
`define LBLK_W 2
`define PBLK_W 3
`define NUM_PBLK 4
`define MAP_WE_BIT 0
`define MAP_PB_LSB 1
`define MAP_PB_MSB 3
`define PRIV_BASE 16'hff00
`define PRIV_W 8
`define MAP_RST 8'h01
`define FLOAT_DATA 8'hff
`define NUM_CPU 2
`define NUM_LBLK 4
`define DATA_W 8
`define MAP_NIB_W 4
`endif

/* File: logic/ram_mapper_pkg.sv */
// Types for the dual processor RAM block mapper.
`default_nettype none
package ram_mapper_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [15:0] addr_t;
endpackage : ram_mapper_pkg
`default_nettype wire

/* File: tb/ram_mapper_checker.sv */
// Port assertions for the RAM block mapper.
`default_nettype none
module ram_mapper_checker (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [1:0] mapWr,
    input wire logic [1:0] memReq,
    input wire logic [1:0] memWr,
    input wire logic [1:0] memRvalid,
    input wire logic [3:0] mapIndex,
    input wire logic [7:0] mapData,
    input wire logic [31:0] memAddr,
    input wire logic [15:0] memRdata
);
    wire logic [1:0] rd;
    wire logic [1:0] v;
    logic [3:0] off;
    assign rd = memReq & ~memWr;
    assign v = memRvalid;
    // Mirror of processor 1 deselect bits, cleared with the map on reset.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            off <= '0;
        end else if (mapWr[1]) begin
            off[mapIndex[3:2]] <= mapData[7];
        end
    end
    sequence deselRead1;
        rd[1] && off[memAddr[31:30]] && !(&memAddr[31:24]);
    endsequence
    default clocking @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    chk_ans_p0: assert property (rd[0] |=> v[0]) else $error("late");
    chk_ans_p1: assert property (rd[1] |=> v[1]) else $error("late");
    chk_quiet_p0: assert property (!rd[0] |=> !v[0]) else $error("extra");
    chk_quiet_p1: assert property (!rd[1] |=> !v[1]) else $error("extra");
    chk_hold_p0: assert property (!rd[0] |=> $stable(memRdata[7:0])) else $error("drift");
    chk_hold_p1: assert property (!rd[1] |=> $stable(memRdata[15:8])) else $error("drift");
    chk_reset_idle: assert property ($fell(sys_rst) |-> !v && &memRdata) else $error("reset");
    chk_card_off: assert property (deselRead1 |=> &memRdata[15:8]) else $error("deselected read");
endmodule : ram_mapper_checker
bind dual_cpu_ram_block_mapper ram_mapper_checker chk(.*);
`default_nettype wire

/* File: tb/core_pair.sv */
// Two behavioural processor cores in front of the mapper.
`default_nettype none
module core_pair (
    input wire logic mclk,
    input wire logic [15:0] memRdata,
    output var logic [1:0] mapWr,
    output var logic [1:0] memReq,
    output var logic [1:0] memWr,
    output var logic [3:0] mapIndex,
    output var logic [7:0] mapData,
    output var logic [31:0] memAddr,
    output var logic [15:0] memWdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {mapWr, memReq, memWr, mapIndex, mapData, memAddr, memWdata} = '0;
    end
    // Map writes always target logical block 1, the block under test.
    task automatic mp(input int p, input logic [3:0] n);
        @(posedge mclk);
        mapWr[p] <= 1'b1;
        mapIndex[2*p +: 2] <= 2'h1;
        mapData[4*p +: 4] <= n;
        @(posedge mclk);
        mapWr[p] <= 1'b0;
    endtask : mp
    task automatic acc(input int p, input logic w, input logic [15:0] a, input logic [7:0] v,
        output logic [7:0] q);
        @(posedge mclk);
        memReq[p] <= 1'b1;
        memWr[p] <= w;
        memAddr[16*p +: 16] <= a;
        memWdata[8*p +: 8] <= v;
        @(posedge mclk);
        memReq[p] <= 1'b0;
        // The address is inverted once released, so a stale value never looks live.
        memAddr[16*p +: 16] <= ~a;
        @(negedge mclk);
        q = memRdata[8*p +: 8];
    endtask : acc
endmodule : core_pair
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the RAM block mapper.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] mapWr;
    logic [1:0] memReq;
    logic [1:0] memWr;
    logic [1:0] memRvalid;
    logic [3:0] mapIndex;
    logic [7:0] mapData;
    logic [31:0] memAddr;
    logic [15:0] memWdata;
    logic [15:0] memRdata;
    logic [7:0] q;
    logic [7:0] r;
    logic [7:0] d [4];
    int err_total;
    int checked;
    int cyc;
    dual_cpu_ram_block_mapper DUT (.*);
    core_pair cores (.*);
    // A code with the top block bit set reads back as the floating bus.
    function automatic logic [7:0] expectRead(input logic [3:0] code, input logic [7:0] stored);
        expectRead = code[3] ? 8'hff : stored;
    endfunction : expectRead
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 900) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(32'h5e3c921b));
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        // Codes run downwards so each read-only pass below code 8 finds the block its enabled twin filled.
        for (int n = 15; n >= 0; n--) begin
            r = 8'($urandom);
            cores.mp(1, 4'(n));
            cores.acc(1, 1'b1, 16'h4123, r, q);
            cores.acc(1, 1'b0, 16'h4123, 8'h00, q);
            if (n < 8 && n % 2 == 1) begin
                d[n / 2] = r;
            end
            chk(q, expectRead(4'(n), d[(n / 2) % 4]));
        end
        for (int b = 0; b < 4; b++) begin
            cores.mp(0, 4'(2 * b));
            cores.acc(0, 1'b0, 16'h4123, 8'h00, q);
            chk(q, d[b]);
        end
        cores.acc(0, 1'b0, 16'h0123, 8'h00, q);
        chk(q, d[0]);
        fork
            cores.acc(0, 1'b1, 16'hff10, r, q);
            cores.acc(1, 1'b1, 16'hff10, ~r, q);
        join
        fork
            cores.acc(0, 1'b0, 16'hff10, 8'h00, q);
            cores.acc(1, 1'b0, 16'hff10, 8'h00, d[1]);
        join
        chk(q, r);
        chk(d[1], ~r);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
